// [rtl/clock_fanout_enable_power_control.sv]
// Output gating, power sequencing, strap latching and registers of the fanout buffer
`timescale 1ns/1ps
module clock_fanout_enable_power_control #(
  parameter bit PUSH_PULL = 1'b0
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic power_good_down_pin,
  input wire logic supply_valid,
  input wire logic input_clock_valid,
  input wire logic freq_select_strap,
  input wire logic [1:0] addr_strap_low,
  input wire logic [1:0] addr_strap_high,
  input wire logic [1:0] pll_bandwidth_strap,
  input wire logic [11:0] output_gate_n,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  output logic [11:0] fanout_clock_true,
  output logic [11:0] fanout_clock_comp,
  output logic [11:0] fanout_drive_en,
  output logic feedback_output_true,
  output logic feedback_output_comp,
  output logic feedback_drive_en,
  output logic pll_enable,
  output logic [1:0] pll_mode,
  output logic freq_select,
  output logic [7:0] bus_address,
  output logic [1:0] seq_state
);

  localparam int SYNC_W = 22;

  // Synchroniser stages for every pin input
  logic [SYNC_W-1:0] sync_meta_q;
  logic [SYNC_W-1:0] sync_q;

  logic [11:0] gate_n_s;
  logic pg_s;
  logic supply_s;
  logic clk_ok_s;
  logic fs_s;
  logic [1:0] sa_lo_s;
  logic [1:0] sa_hi_s;
  logic [1:0] bw_s;

  logic pg_prev_q;
  logic pg_seen_q;
  logic pg_rise;
  logic pd_pin_low;

  logic fs_latch_q;
  logic [1:0] mode_latch_q;
  logic [7:0] addr_latch_q;

  logic [1:0] sw_mode_q;
  logic sw_en_q;
  logic [11:0] oe_q;

  clock_fanout_pkg::seq_state_e seq_q;
  logic [clock_fanout_pkg::SEQ_CNT_W-1:0] seq_cnt_q;
  logic seq_go;
  logic [1:0] mode_eff;

  logic phase_q;
  logic running;
  logic tick;
  logic rise_true;
  logic [1:0] pd_hits_q;
  logic pd_stop_q;

  logic [11:0] want_on;
  logic [11:0] active;

  // Two flops on every asynchronous pin before any use
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_meta_q <= '0;
      sync_q <= '0;
    end else begin
      sync_meta_q <= {output_gate_n, power_good_down_pin, supply_valid, input_clock_valid,
                      freq_select_strap, addr_strap_low, addr_strap_high, pll_bandwidth_strap};
      sync_q <= sync_meta_q;
    end
  end

  assign gate_n_s = sync_q[21:10];
  assign pg_s = sync_q[9];
  assign supply_s = sync_q[8];
  assign clk_ok_s = sync_q[7];
  assign fs_s = sync_q[6];
  assign sa_lo_s = sync_q[5:4];
  assign sa_hi_s = sync_q[3:2];
  assign bw_s = sync_q[1:0];

  // Bus address from the two tri-level straps
  function automatic logic [7:0] addr_lookup(input logic [1:0] hi, input logic [1:0] lo);
    logic [7:0] a;
    a = clock_fanout_pkg::ADDR_HH;
    unique case (hi)
      clock_fanout_pkg::TRI_LOW: a = (lo == clock_fanout_pkg::TRI_LOW) ? clock_fanout_pkg::ADDR_LL :
                                     (lo == clock_fanout_pkg::TRI_MID) ? clock_fanout_pkg::ADDR_LM :
                                     clock_fanout_pkg::ADDR_LH;
      clock_fanout_pkg::TRI_MID: a = (lo == clock_fanout_pkg::TRI_LOW) ? clock_fanout_pkg::ADDR_ML :
                                     (lo == clock_fanout_pkg::TRI_MID) ? clock_fanout_pkg::ADDR_MM :
                                     clock_fanout_pkg::ADDR_MH;
      default: a = (lo == clock_fanout_pkg::TRI_LOW) ? clock_fanout_pkg::ADDR_HL :
                   (lo == clock_fanout_pkg::TRI_MID) ? clock_fanout_pkg::ADDR_HM :
                   clock_fanout_pkg::ADDR_HH;
    endcase
    return a;
  endfunction : addr_lookup

  // PLL mode from the bandwidth strap
  function automatic logic [1:0] mode_lookup(input logic [1:0] bw);
    logic [1:0] m;
    m = clock_fanout_pkg::MODE_WIDE;
    if (bw == clock_fanout_pkg::TRI_LOW) begin
      m = clock_fanout_pkg::MODE_NARROW;
    end else if (bw == clock_fanout_pkg::TRI_MID) begin
      m = clock_fanout_pkg::MODE_BYPASS;
    end
    return m;
  endfunction : mode_lookup

  // Power-good edge; the pin turns into power-down after its first rise
  assign pg_rise = pg_s & ~pg_prev_q;
  assign pd_pin_low = pg_seen_q & ~pg_s;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pg_prev_q <= 1'b0;
      pg_seen_q <= 1'b0;
    end else begin
      pg_prev_q <= pg_s;
      if (pg_rise) begin
        pg_seen_q <= 1'b1;
      end
    end
  end

  // Strap capture on the first power-good rise
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      fs_latch_q <= 1'b0;
      mode_latch_q <= clock_fanout_pkg::MODE_NARROW;
      addr_latch_q <= 8'h00;
    end else if (pg_rise && !pg_seen_q) begin
      fs_latch_q <= fs_s;
      mode_latch_q <= mode_lookup(bw_s);
      addr_latch_q <= addr_lookup(sa_hi_s, sa_lo_s);
    end
  end

  // Software override only counts once its enable bit is set
  assign mode_eff = sw_en_q ? sw_mode_q : mode_latch_q;

  // Power-up sequencer
  assign seq_go = pg_s & clk_ok_s & ~pd_stop_q;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      seq_q <= clock_fanout_pkg::SEQ_OFF;
      seq_cnt_q <= '0;
    end else if (!supply_s) begin
      seq_q <= clock_fanout_pkg::SEQ_OFF;
      seq_cnt_q <= '0;
    end else begin
      unique case (seq_q)
        clock_fanout_pkg::SEQ_OFF: begin
          seq_q <= clock_fanout_pkg::SEQ_SUPPLY;
          seq_cnt_q <= '0;
        end
        clock_fanout_pkg::SEQ_SUPPLY: begin
          if (seq_cnt_q == clock_fanout_pkg::SEQ_CNT_W'(clock_fanout_pkg::STARTUP_DELAY_CYC - 1)) begin
            seq_q <= clock_fanout_pkg::SEQ_WAIT_CLK;
            seq_cnt_q <= '0;
          end else begin
            seq_cnt_q <= seq_cnt_q + 1'b1;
          end
        end
        clock_fanout_pkg::SEQ_WAIT_CLK: begin
          if (!seq_go) begin
            seq_cnt_q <= '0;
          end else if (mode_eff == clock_fanout_pkg::MODE_BYPASS ||
                       seq_cnt_q == clock_fanout_pkg::SEQ_CNT_W'(clock_fanout_pkg::LOCK_TIME_CYC - 1)) begin
            seq_q <= clock_fanout_pkg::SEQ_RUN;
            seq_cnt_q <= '0;
          end else begin
            seq_cnt_q <= seq_cnt_q + 1'b1;
          end
        end
        clock_fanout_pkg::SEQ_RUN: begin
          if (!clk_ok_s || pd_stop_q) begin
            seq_q <= clock_fanout_pkg::SEQ_WAIT_CLK;
            seq_cnt_q <= '0;
          end
        end
      endcase
    end
  end

  // Internal output clock: one toggle per cycle while running
  assign running = (seq_q == clock_fanout_pkg::SEQ_RUN) & ~pd_stop_q;
  assign tick = running & phase_q;
  assign rise_true = running & ~phase_q;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_q <= 1'b0;
    end else if (running) begin
      phase_q <= ~phase_q;
    end else begin
      phase_q <= 1'b0;
    end
  end

  // Power-down: count low samples at comp rising, stop at comp falling
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pd_hits_q <= 2'h0;
      pd_stop_q <= 1'b0;
    end else begin
      if (!pd_pin_low) begin
        pd_hits_q <= 2'h0;
        pd_stop_q <= 1'b0;
      end else if (!running) begin
        pd_stop_q <= pd_stop_q | (seq_q != clock_fanout_pkg::SEQ_RUN);
      end else if (tick && pd_hits_q != 2'(clock_fanout_pkg::PD_HITS)) begin
        pd_hits_q <= pd_hits_q + 1'b1;
      end else if (rise_true && pd_hits_q == 2'(clock_fanout_pkg::PD_HITS)) begin
        pd_stop_q <= 1'b1;
      end
    end
  end

  // One start/stop controller per fanout output pair; the feedback pair has none
  genvar gi;
  generate
    for (gi = 0; gi < clock_fanout_pkg::NUM_OUT; gi++) begin : g_chan
      assign want_on[gi] = oe_q[gi] & ~gate_n_s[gi];
      gate_chan u_gate (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .want_on(want_on[gi]),
        .period_tick(tick),
        .active_q(active[gi])
      );
    end
  endgenerate

  // Output legs; disabled legs sit low, enable drops unless push-pull
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      fanout_clock_true <= 12'h000;
      fanout_clock_comp <= 12'h000;
      fanout_drive_en <= 12'h000;
    end else begin
      fanout_clock_true <= {12{running & phase_q}} & active;
      fanout_clock_comp <= {12{running & ~phase_q}} & active;
      fanout_drive_en <= ({12{running}} & active) | {12{PUSH_PULL}};
    end
  end

  // Feedback pair ignores the gates but stops on power-down
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      feedback_output_true <= 1'b0;
      feedback_output_comp <= 1'b0;
      feedback_drive_en <= 1'b0;
    end else begin
      feedback_output_true <= running & phase_q;
      feedback_output_comp <= running & ~phase_q;
      feedback_drive_en <= running | PUSH_PULL;
    end
  end

  // PLL control and latched configuration outputs
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pll_enable <= 1'b0;
      pll_mode <= clock_fanout_pkg::MODE_NARROW;
      freq_select <= 1'b0;
      bus_address <= 8'h00;
      seq_state <= 2'h0;
    end else begin
      pll_enable <= supply_s & seq_go & (mode_eff != clock_fanout_pkg::MODE_BYPASS) &
                    ((seq_q == clock_fanout_pkg::SEQ_WAIT_CLK) || (seq_q == clock_fanout_pkg::SEQ_RUN));
      pll_mode <= mode_eff;
      freq_select <= fs_latch_q;
      bus_address <= addr_latch_q;
      seq_state <= seq_q;
    end
  end

  // Register writes
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sw_mode_q <= clock_fanout_pkg::SW_MODE_RST;
      sw_en_q <= clock_fanout_pkg::SW_EN_RST;
      oe_q <= clock_fanout_pkg::OE_RST;
    end else if (reg_write) begin
      unique case (reg_addr)
        clock_fanout_pkg::REG_MODE: begin
          sw_mode_q <= reg_wdata[clock_fanout_pkg::MODE_SW_LSB +: 2];
          sw_en_q <= reg_wdata[clock_fanout_pkg::MODE_SW_EN_BIT];
        end
        clock_fanout_pkg::REG_OE_LO: oe_q[7:0] <= reg_wdata;
        clock_fanout_pkg::REG_OE_HI: oe_q[11:8] <= reg_wdata[3:0];
        default: begin
        end
      endcase
    end
  end

  // Register reads, data valid the cycle after the strobe
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      unique case (reg_addr)
        clock_fanout_pkg::REG_MODE: begin
          reg_rdata <= 8'h00;
          reg_rdata[clock_fanout_pkg::MODE_FS_BIT] <= fs_latch_q;
          reg_rdata[clock_fanout_pkg::MODE_SW_LSB +: 2] <= sw_mode_q;
          reg_rdata[clock_fanout_pkg::MODE_SW_EN_BIT] <= sw_en_q;
          reg_rdata[clock_fanout_pkg::MODE_LATCH_LSB +: 2] <= mode_latch_q;
        end
        clock_fanout_pkg::REG_OE_LO: reg_rdata <= oe_q[7:0];
        clock_fanout_pkg::REG_OE_HI: reg_rdata <= {4'h0, oe_q[11:8]};
        clock_fanout_pkg::REG_PIN_LO: reg_rdata <= gate_n_s[7:0];
        clock_fanout_pkg::REG_PIN_HI: reg_rdata <= {4'h0, gate_n_s[11:8]};
        clock_fanout_pkg::REG_STATUS: reg_rdata <= {2'h0, clk_ok_s, pg_seen_q, running, pd_stop_q, seq_q};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule : clock_fanout_enable_power_control

// [rtl/clock_fanout_pkg.sv]
// Constants, encodings and state types for the clock fanout control block
package clock_fanout_pkg;

  localparam int NUM_OUT = 12;
  localparam int CLK_MHZ = 40;

  // Sequencer timing, in nanoseconds and clock cycles
  localparam int STARTUP_DELAY_NS = 100000;
  localparam int STARTUP_DELAY_CYC = (STARTUP_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int LOCK_TIME_NS = 50000;
  localparam int LOCK_TIME_CYC = (LOCK_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int SEQ_CNT_W = 12;

  // Gate latency in output periods, and low samples before power-down
  localparam int GATE_LATENCY = 6;
  localparam int GATE_CNT_W = 4;
  localparam int PD_HITS = 2;

  typedef enum logic [1:0] {
    SEQ_OFF,
    SEQ_SUPPLY,
    SEQ_WAIT_CLK,
    SEQ_RUN
  } seq_state_e;

  // Tri-level strap encodings
  localparam logic [1:0] TRI_LOW = 2'h0;
  localparam logic [1:0] TRI_MID = 2'h1;
  localparam logic [1:0] TRI_HIGH = 2'h2;

  // PLL mode encodings
  localparam logic [1:0] MODE_NARROW = 2'h0;
  localparam logic [1:0] MODE_BYPASS = 2'h1;
  localparam logic [1:0] MODE_WIDE = 2'h3;

  // Bus addresses by strap pair
  localparam logic [7:0] ADDR_LL = 8'hd8;
  localparam logic [7:0] ADDR_LM = 8'hda;
  localparam logic [7:0] ADDR_LH = 8'hde;
  localparam logic [7:0] ADDR_ML = 8'hc2;
  localparam logic [7:0] ADDR_MM = 8'hc4;
  localparam logic [7:0] ADDR_MH = 8'hc6;
  localparam logic [7:0] ADDR_HL = 8'hca;
  localparam logic [7:0] ADDR_HM = 8'hcc;
  localparam logic [7:0] ADDR_HH = 8'hce;

  // Register offsets
  localparam logic [2:0] REG_MODE = 3'h0;
  localparam logic [2:0] REG_OE_LO = 3'h1;
  localparam logic [2:0] REG_OE_HI = 3'h2;
  localparam logic [2:0] REG_PIN_LO = 3'h3;
  localparam logic [2:0] REG_PIN_HI = 3'h4;
  localparam logic [2:0] REG_STATUS = 3'h5;

  // Mode register fields
  localparam int MODE_FS_BIT = 0;
  localparam int MODE_SW_LSB = 1;
  localparam int MODE_SW_EN_BIT = 3;
  localparam int MODE_LATCH_LSB = 6;

  // Reset values
  localparam logic [1:0] SW_MODE_RST = 2'h3;
  localparam logic SW_EN_RST = 1'b0;
  localparam logic [11:0] OE_RST = 12'hfff;

endpackage : clock_fanout_pkg

// [rtl/gate_chan.sv]
// Per-output start/stop controller aligned to output clock periods
`timescale 1ns/1ps
module gate_chan (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic want_on,
  input wire logic period_tick,
  output logic active_q
);

  logic [clock_fanout_pkg::GATE_CNT_W-1:0] cnt_q;

  // Switch only at a true-leg falling moment, after a fixed period count
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      active_q <= 1'b0;
      cnt_q <= '0;
    end else if (want_on == active_q) begin
      cnt_q <= '0;
    end else if (period_tick) begin
      if (cnt_q == clock_fanout_pkg::GATE_CNT_W'(clock_fanout_pkg::GATE_LATENCY - 1)) begin
        active_q <= want_on;
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

endmodule : gate_chan

// [testbench/clock_fanout_enable_power_control_asserts.sv]
// Concurrent checks on the fanout control block ports
`timescale 1ns/1ps
module clock_fanout_enable_power_control_asserts (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic power_good_down_pin,
  input wire logic input_clock_valid,
  input wire logic [11:0] output_gate_n,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic [11:0] fanout_clock_true,
  input wire logic [11:0] fanout_clock_comp,
  input wire logic [11:0] fanout_drive_en,
  input wire logic feedback_drive_en,
  input wire logic pll_enable,
  input wire logic freq_select,
  input wire logic [7:0] bus_address,
  input wire logic [1:0] seq_state
);
  logic [7:0] oe_lo_q;
  logic [7:0] pg_q;
  logic seen_q;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // Shadow of low enable byte, and flag once straps are surely latched
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      oe_lo_q <= 8'hff;
      pg_q <= 8'h00;
      seen_q <= 1'b0;
    end else begin
      if (reg_write && reg_addr == clock_fanout_pkg::REG_OE_LO) oe_lo_q <= reg_wdata;
      pg_q <= {pg_q[6:0], power_good_down_pin};
      seen_q <= seen_q | (&pg_q);
    end
  end
  // Pair 0 keeps running four periods, or stays parked seven cycles
  sequence runs_s; fanout_drive_en[0] [*8]; endsequence
  sequence parked_s; !fanout_drive_en[0] [*7]; endsequence
  chk_off_legs_low: assert property ((~fanout_drive_en & (fanout_clock_true | fanout_clock_comp)) == 12'h000)
    else $error("disabled pair shows a high leg");
  chk_pair_toggles: assert property (fanout_drive_en[0] && $past(fanout_drive_en[0]) |-> $changed(fanout_clock_true[0]))
    else $error("running pair did not toggle");
  chk_legs_opposite: assert property ((fanout_drive_en & ~(fanout_clock_true ^ fanout_clock_comp)) == 12'h000)
    else $error("running pair legs not complementary");
  chk_gate_stop: assert property ($rose(output_gate_n[0]) && fanout_drive_en[0] |-> runs_s ##[1:17] !fanout_drive_en[0])
    else $error("gate stop latency out of range");
  chk_gate_start: assert property ($fell(output_gate_n[0]) && oe_lo_q[0] && !fanout_drive_en[0] && seq_state == 2'h3
    |-> parked_s ##[1:17] fanout_drive_en[0])
    else $error("gate start latency out of range");
  chk_oe_readback: assert property (reg_read && reg_addr == clock_fanout_pkg::REG_OE_LO |=> reg_rdata == $past(oe_lo_q))
    else $error("enable byte read back wrong");
  chk_pd_stop: assert property ($fell(power_good_down_pin) && seq_state == 2'h3
    |-> ##[1:12] (fanout_drive_en == 12'h000 && !feedback_drive_en))
    else $error("power-down did not stop outputs");
  chk_early_off: assert property (seq_state inside {2'h0, 2'h1} |-> fanout_drive_en == 12'h000 && !pll_enable)
    else $error("outputs or pll on before supply delay");
  chk_run_needs_clk: assert property ($rose(seq_state == 2'h3) |-> $past(input_clock_valid, 2))
    else $error("run entered without input clock");
  chk_strap_hold: assert property (seen_q |-> $stable(bus_address) && $stable(freq_select))
    else $error("latched straps changed");
endmodule : clock_fanout_enable_power_control_asserts

// [testbench/board_controller_model.sv]
// Board controller: supply, power-good or power-down pin, input clock
`timescale 1ns/1ps
module board_controller_model (
  input wire logic ref_clk,
  input wire logic power_on,
  input wire logic pd_req,
  input wire logic clk_req,
  output logic supply_valid,
  output logic power_good_down_pin,
  output logic input_clock_valid
);
  logic [5:0] up_cnt_q = 6'h00;
  logic [3:0] pd_cnt_q = 4'h0;
  logic supply_q = 1'b0;
  logic pg_pin_q = 1'b0;
  logic clk_ok_q = 1'b0;
  // Pins come straight from the model flops
  assign supply_valid = supply_q;
  assign power_good_down_pin = pg_pin_q;
  assign input_clock_valid = clk_ok_q;
  // Supply ramps first, power-good only later
  always @(posedge ref_clk) begin
    if (!power_on) up_cnt_q <= 6'h00;
    else if (up_cnt_q != 6'h3f) up_cnt_q <= up_cnt_q + 6'h01;
    supply_q <= power_on && up_cnt_q >= 6'h0a;
    pg_pin_q <= up_cnt_q >= 6'h1e && !pd_req;
  end
  // Clock stops only after power-down has been held a while
  always @(posedge ref_clk) begin
    if (power_good_down_pin) pd_cnt_q <= 4'h0;
    else if (pd_cnt_q != 4'hf) pd_cnt_q <= pd_cnt_q + 4'h1;
    if (clk_req) clk_ok_q <= 1'b1;
    else if (pd_cnt_q == 4'hf) clk_ok_q <= 1'b0;
  end
endmodule : board_controller_model

// [testbench/clock_fanout_enable_power_control_bench.sv]
// Self-checking bench for the fanout control block
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin n_errors++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, gt); end end
module clock_fanout_enable_power_control_bench;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic power_on = 1'b0;
  logic pd_req = 1'b0;
  logic clk_req = 1'b0;
  logic supply_valid, power_good_down_pin, input_clock_valid;
  logic freq_select_strap = 1'b0;
  logic [1:0] addr_strap_low = 2'h0;
  logic [1:0] addr_strap_high = 2'h0;
  logic [1:0] pll_bandwidth_strap = 2'h0;
  logic [11:0] output_gate_n = 12'h000;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata, bus_address, e;
  logic [11:0] fanout_clock_true, fanout_clock_comp, fanout_drive_en, exp_en;
  logic feedback_drive_en, pll_enable, freq_select, feedback_output_true, feedback_output_comp;
  logic [1:0] pll_mode, seq_state;
  logic [31:0] rng = 32'h0000af95; // Seed 44949
  logic [7:0] exp_q[$];
  logic rd_d = 1'b0;
  int n_errors = 0;
  int num_checks = 0;
  int n;
  logic [7:0] addr_tab [9] = '{8'hd8, 8'hda, 8'hde, 8'hc2, 8'hc4, 8'hc6, 8'hca, 8'hcc, 8'hce};
  logic [1:0] mode_tab [3] = '{2'h0, 2'h1, 2'h3};
  clock_fanout_enable_power_control #(.PUSH_PULL(1'b0)) i_clock_fanout_enable_power_control (
    .ref_clk(ref_clk), .arst_n(arst_n), .power_good_down_pin(power_good_down_pin),
    .supply_valid(supply_valid), .input_clock_valid(input_clock_valid),
    .freq_select_strap(freq_select_strap), .addr_strap_low(addr_strap_low), .addr_strap_high(addr_strap_high),
    .pll_bandwidth_strap(pll_bandwidth_strap), .output_gate_n(output_gate_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .fanout_clock_true(fanout_clock_true), .fanout_clock_comp(fanout_clock_comp),
    .fanout_drive_en(fanout_drive_en), .feedback_output_true(feedback_output_true),
    .feedback_output_comp(feedback_output_comp),
    .feedback_drive_en(feedback_drive_en), .pll_enable(pll_enable), .pll_mode(pll_mode),
    .freq_select(freq_select), .bus_address(bus_address), .seq_state(seq_state));
  board_controller_model i_board_controller_model (.ref_clk(ref_clk), .power_on(power_on), .pd_req(pd_req),
    .clk_req(clk_req), .supply_valid(supply_valid), .power_good_down_pin(power_good_down_pin),
    .input_clock_valid(input_clock_valid));
  // Clock and xorshift source
  always #12.5 ref_clk = ~ref_clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
  endtask : cyc
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    cyc(1);
    reg_write <= 1'b0;
    cyc(1);
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] x);
    exp_q.push_back(x);
    reg_addr <= a;
    reg_read <= 1'b1;
    cyc(1);
    reg_read <= 1'b0;
    cyc(1);
  endtask : rd
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  // Read data compared the cycle after each read strobe
  always @(posedge ref_clk) begin
    if (rd_d) begin
      e = exp_q.pop_front();
      `CHK("reg_rdata", e, reg_rdata)
    end
    rd_d <= reg_read;
  end
  // Watchdog sized well above the roughly 10300 cycles of tests
  initial begin
    #1000000;
    n_errors++;
    summarize();
  end
  // Main sequence
  initial begin
    cyc(5);
    arst_n <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      addr_strap_high <= 2'(i / 3);
      addr_strap_low <= 2'(i % 3);
      pll_bandwidth_strap <= 2'(i % 3);
      freq_select_strap <= i[0];
      cyc(2);
      power_on <= 1'b1;
      cyc(50);
      `CHK("bus_address", addr_tab[i], bus_address)
      `CHK("freq_select", i[0], freq_select)
      `CHK("pll_mode", mode_tab[i % 3], pll_mode)
      `CHK("seq_supply", 2'h1, seq_state)
      rd(clock_fanout_pkg::REG_MODE, {mode_tab[i % 3], 3'h0, 2'h3, i[0]});
      addr_strap_low <= ~addr_strap_low;
      freq_select_strap <= ~i[0];
      cyc(10);
      `CHK("addr_kept", addr_tab[i], bus_address)
      if (i < 8) begin
        power_on <= 1'b0;
        arst_n <= 1'b0;
        cyc(2);
        arst_n <= 1'b1;
        cyc(2);
      end
    end
    $display("strap test done");
    cyc(5000);
    `CHK("seq_wait", 2'h2, seq_state)
    `CHK("no_clk_off", 12'h000, fanout_drive_en)
    for (int m = 0; m < 3; m++) begin
      wr(clock_fanout_pkg::REG_MODE, {5'h01, mode_tab[m], 1'b0});
      cyc(4);
      `CHK("pll_mode_sw", mode_tab[m], pll_mode)
      rd(clock_fanout_pkg::REG_MODE, {2'h3, 2'h0, 1'b1, mode_tab[m], 1'b0});
    end
    wr(clock_fanout_pkg::REG_MODE, 8'h00);
    cyc(4);
    `CHK("pll_mode_hw", 2'h3, pll_mode)
    $display("mode test done");
    clk_req <= 1'b1;
    n = 0;
    while (seq_state !== 2'h3 && n < 72000) begin
      cyc(1);
      n++;
    end
    `CHK("run_in_time", 1'b1, n < 72000)
    cyc(30);
    `CHK("all_on", 14'h3fff, {pll_enable, feedback_drive_en, fanout_drive_en})
    `CHK("fb_pair", 1'b1, feedback_output_true ^ feedback_output_comp)
    rd(clock_fanout_pkg::REG_STATUS, 8'h3b);
    rd(clock_fanout_pkg::REG_OE_LO, 8'hff);
    rd(clock_fanout_pkg::REG_OE_HI, 8'h0f);
    rd(3'h6, 8'h00);
    wr(clock_fanout_pkg::REG_PIN_LO, 8'h5a);
    rd(clock_fanout_pkg::REG_PIN_LO, 8'h00);
    $display("power-up test done");
    for (int k = 0; k < 7; k++) begin
      rng = xs(rng);
      output_gate_n <= {rng[11:1], k[0]};
      cyc(30);
      exp_en = {rng[23:13], 1'b1};
      wr(clock_fanout_pkg::REG_OE_LO, exp_en[7:0]);
      wr(clock_fanout_pkg::REG_OE_HI, {4'h0, exp_en[11:8]});
      cyc(30);
      exp_en = exp_en & ~output_gate_n;
      `CHK("drive_en", exp_en, fanout_drive_en)
      rd(clock_fanout_pkg::REG_PIN_LO, output_gate_n[7:0]);
      rd(clock_fanout_pkg::REG_PIN_HI, {4'h0, output_gate_n[11:8]});
      rd(clock_fanout_pkg::REG_OE_HI, {4'h0, rng[23:20]});
    end
    $display("gate test done");
    pd_req <= 1'b1;
    cyc(20);
    `CHK("pd_off", 14'h0000, {pll_enable, feedback_drive_en, fanout_drive_en})
    `CHK("fb_legs_off", 2'h0, {feedback_output_true, feedback_output_comp})
    rd(clock_fanout_pkg::REG_STATUS, 8'h36);
    clk_req <= 1'b0;
    cyc(40);
    clk_req <= 1'b1;
    cyc(10);
    pd_req <= 1'b0;
    n = 0;
    while (fanout_drive_en !== exp_en && n < 12000) begin
      cyc(1);
      n++;
    end
    `CHK("pd_release", 1'b1, n < 12000)
    $display("power-down test done");
    summarize();
  end
endmodule : clock_fanout_enable_power_control_bench
bind clock_fanout_enable_power_control clock_fanout_enable_power_control_asserts
  i_clock_fanout_enable_power_control_asserts (.ref_clk(ref_clk), .arst_n(arst_n),
  .power_good_down_pin(power_good_down_pin), .input_clock_valid(input_clock_valid),
  .output_gate_n(output_gate_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
  .reg_read(reg_read), .reg_rdata(reg_rdata), .fanout_clock_true(fanout_clock_true),
  .fanout_clock_comp(fanout_clock_comp), .fanout_drive_en(fanout_drive_en),
  .feedback_drive_en(feedback_drive_en), .pll_enable(pll_enable), .freq_select(freq_select),
  .bus_address(bus_address), .seq_state(seq_state));
